// ==== pkg/mcpwm_consts.vh ====
`ifndef MCPWM_CONSTS_VH
`define MCPWM_CONSTS_VH

// ==========================================================
// Sizes
`define MCPWM_NCH          12
`define MCPWM_DUTY_W       11
`define MCPWM_CTRL_W       6
`define MCPWM_DIV_W        8

// ==========================================================
// Register byte offsets (aligned words) and their word indices
`define MCPWM_ADR_GLOBAL   8'h00
`define MCPWM_ADR_STATUS   8'h04
`define MCPWM_ADR_CTRL0    8'h40
`define MCPWM_ADR_DUTY0    8'h80
`define MCPWM_IDX_CTRL0    6'h10
`define MCPWM_IDX_DUTY0    6'h20

// ==========================================================
// Global register fields
`define MCPWM_G_FAST       0
`define MCPWM_G_DITHER     1
`define MCPWM_G_DIV_LO     8
`define MCPWM_G_DIV_HI     15

// ==========================================================
// Channel control fields
`define MCPWM_C_ALIGN_LO   0
`define MCPWM_C_ALIGN_HI   1
`define MCPWM_C_MODE_LO    2
`define MCPWM_C_MODE_HI    3
`define MCPWM_C_FREEWHEEL  4
`define MCPWM_C_SIGN       5

// ==========================================================
// Alignment codes
`define MCPWM_AL_OFF       2'h0
`define MCPWM_AL_LEFT      2'h1
`define MCPWM_AL_RIGHT     2'h2
`define MCPWM_AL_CENTER    2'h3

// ==========================================================
// Output mode codes
`define MCPWM_OM_HALF_M    2'h0
`define MCPWM_OM_HALF_P    2'h1
`define MCPWM_OM_FULL      2'h2
`define MCPWM_OM_DUAL      2'h3

// ==========================================================
// Counter tops and reset values
`define MCPWM_TOP_11       11'h7ff
`define MCPWM_TOP_10       11'h3ff
`define MCPWM_TOP_7        11'h07f
`define MCPWM_CNT_ZERO     11'h000
`define MCPWM_CNT_ONE      11'h001
`define MCPWM_DIV_RST      8'h00
`define MCPWM_DIV_ZERO     8'h00
`define MCPWM_DIV_ONE      8'h01

`endif

// ==== design/mcpwm_prescale.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_consts.vh"

module mcpwm_prescale (
    // Clock and reset
    input  wire                     clk_i,
    input  wire                     rst_i,
    // Divide setting: tick every div_i+1 clocks
    input  wire [`MCPWM_DIV_W-1:0]  div_i,
    // Counter enable pulse
    output reg                      tick_o
);

    reg [`MCPWM_DIV_W-1:0] cnt_reg;

    // ==========================================================
    // Divider
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= `MCPWM_DIV_ZERO;
            tick_o  <= 1'b0;
        end else if (cnt_reg >= div_i) begin
            cnt_reg <= `MCPWM_DIV_ZERO;
            tick_o  <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + `MCPWM_DIV_ONE;
            tick_o  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== design/mcpwm_channel.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_consts.vh"

module mcpwm_channel (
    // Clock and reset
    input  wire                      clk_i,
    input  wire                      rst_i,
    // Count enable
    input  wire                      tick_i,
    // Global settings
    input  wire                      fast_i,
    input  wire                      dither_i,
    // Channel settings
    input  wire [1:0]                align_i,
    input  wire [`MCPWM_DUTY_W-1:0]  duty_i,
    // Duty window flag
    output wire                      active_o
);

    reg  [`MCPWM_DUTY_W-1:0] cnt_reg;
    reg  [`MCPWM_DUTY_W-1:0] duty_reg;
    reg                      down_reg;
    reg                      phase_reg;
    reg  [`MCPWM_DUTY_W-1:0] top;
    reg  [`MCPWM_DUTY_W-1:0] duty_eff;
    reg                      act;
    wire                     enabled = (align_i != `MCPWM_AL_OFF);

    // Counter top and effective duty per resolution
    always @* begin
        if (fast_i) begin
            top      = `MCPWM_TOP_7;
            duty_eff = {4'h0, duty_reg[6:0]};
        end else if (dither_i) begin
            top      = `MCPWM_TOP_10;
            duty_eff = {1'b0, duty_reg[10:1]}
                     + {10'h000, duty_reg[0] & phase_reg};
        end else begin
            top      = `MCPWM_TOP_11;
            duty_eff = duty_reg;
        end
    end

    // Duty window per alignment
    always @* begin
        case (align_i)
            `MCPWM_AL_LEFT:   act = (cnt_reg < duty_eff);
            `MCPWM_AL_RIGHT:  act = ((top - cnt_reg) < duty_eff);
            `MCPWM_AL_CENTER: act = (cnt_reg < duty_eff);
            default:          act = 1'b0;
        endcase
    end

    assign active_o = act;

    // ==========================================================
    // Period counter, duty reloaded at each period start
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg   <= `MCPWM_CNT_ZERO;
            duty_reg  <= `MCPWM_CNT_ZERO;
            down_reg  <= 1'b0;
            phase_reg <= 1'b0;
        end else if (!enabled) begin
            cnt_reg   <= `MCPWM_CNT_ZERO;
            duty_reg  <= duty_i;
            down_reg  <= 1'b0;
        end else if (tick_i) begin
            if (align_i == `MCPWM_AL_CENTER) begin
                if (!down_reg) begin
                    if (cnt_reg >= top) begin
                        down_reg <= 1'b1;
                        cnt_reg  <= cnt_reg - `MCPWM_CNT_ONE;
                    end else begin
                        cnt_reg  <= cnt_reg + `MCPWM_CNT_ONE;
                    end
                end else if (cnt_reg <= `MCPWM_CNT_ONE) begin
                    cnt_reg   <= `MCPWM_CNT_ZERO;
                    down_reg  <= 1'b0;
                    duty_reg  <= duty_i;
                    phase_reg <= ~phase_reg;
                end else begin
                    cnt_reg  <= cnt_reg - `MCPWM_CNT_ONE;
                end
            end else if (cnt_reg >= top) begin
                cnt_reg   <= `MCPWM_CNT_ZERO;
                duty_reg  <= duty_i;
                phase_reg <= ~phase_reg;
                down_reg  <= 1'b0;
            end else begin
                cnt_reg  <= cnt_reg + `MCPWM_CNT_ONE;
                down_reg <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/mcpwm_top.v ====
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "mcpwm_consts.vh"

// How it works
// - Global fast bit clear gives 11-bit resolution, set gives 7-bit.
// - Global dither bit applies dithering to every channel or none.
// - Twelve channels, each driving a minus and a plus pin, 24 pins.
// - Per-channel 10/11-bit counter; dither yields effective 11-bit duty.
// - In fast mode one byte write updates a channel's whole duty.
// - Each channel picks left, right or center via its alignment field.
// - Minus pin PWM with plus pin held high gives positive coil current.
// - Dual full H-bridge only if both pair channels enabled and mode 11.
// - A lone mode-11 channel runs full H-bridge, its partner as set.
// - Left aligned period starts active: low if freewheel 0, else high.
// - Left aligned goes inactive after duty counts, opposite level.
module mcpwm_top (
    // Clock and reset
    input  wire                   clk_i,
    input  wire                   rst_i,
    // Wishbone slave
    input  wire                   wb_cyc_i,
    input  wire                   wb_stb_i,
    input  wire                   wb_we_i,
    input  wire [7:0]             wb_adr_i,
    input  wire [3:0]             wb_sel_i,
    input  wire [31:0]            wb_dat_i,
    output reg  [31:0]            wb_dat_o,
    output reg                    wb_ack_o,
    // Coil pins, index 2*(motor-1)+coil
    output reg  [`MCPWM_NCH-1:0]  coil_minus_o,
    output reg  [`MCPWM_NCH-1:0]  coil_plus_o
);

    // ==========================================================
    // Register storage
    reg                       fast_reg;
    reg                       jitter_spread_enable_reg;
    reg  [`MCPWM_DIV_W-1:0]   div_reg;
    reg  [`MCPWM_CTRL_W-1:0]  ctrl_reg [0:`MCPWM_NCH-1];
    reg  [`MCPWM_DUTY_W-1:0]  duty_reg [0:`MCPWM_NCH-1];

    wire                      tick;
    wire [`MCPWM_NCH-1:0]     active;
    wire [`MCPWM_NCH-1:0]     minus_next;
    wire [`MCPWM_NCH-1:0]     plus_next;

    // Bus decode
    wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr       = req & wb_we_i;
    wire [5:0] word     = wb_adr_i[7:2];
    wire [5:0] ctrl_off = word - `MCPWM_IDX_CTRL0;
    wire [5:0] duty_off = word - `MCPWM_IDX_DUTY0;
    wire       in_ctrl  = (wb_adr_i >= `MCPWM_ADR_CTRL0)
                        && (ctrl_off < `MCPWM_NCH);
    wire       in_duty  = (wb_adr_i >= `MCPWM_ADR_DUTY0)
                        && (duty_off < `MCPWM_NCH);
    wire [3:0] ctrl_idx = ctrl_off[3:0];
    wire [3:0] duty_idx = duty_off[3:0];
    wire       wr_global = wr && (wb_adr_i[7:2] == `MCPWM_ADR_GLOBAL >> 2);

    reg  [31:0] rd_data;
    integer     i;

    // ==========================================================
    // Global register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_reg                 <= 1'b0;
            jitter_spread_enable_reg <= 1'b0;
            div_reg                  <= `MCPWM_DIV_RST;
        end else if (wr_global) begin
            if (wb_sel_i[0]) begin
                fast_reg <= wb_dat_i[`MCPWM_G_FAST];
                jitter_spread_enable_reg <=
                    wb_dat_i[`MCPWM_G_DITHER];
            end
            if (wb_sel_i[1]) begin
                div_reg <= wb_dat_i[`MCPWM_G_DIV_HI:`MCPWM_G_DIV_LO];
            end
        end
    end

    // ==========================================================
    // Channel register writes, one process for the whole array
    always @(posedge clk_i) begin
        for (i = 0; i < `MCPWM_NCH; i = i + 1) begin
            if (rst_i) begin
                ctrl_reg[i] <= {`MCPWM_CTRL_W{1'b0}};
                duty_reg[i] <= {`MCPWM_DUTY_W{1'b0}};
            end else if (wr) begin
                if (in_ctrl && ctrl_idx == i && wb_sel_i[0]) begin
                    ctrl_reg[i] <= wb_dat_i[`MCPWM_CTRL_W-1:0];
                end
                if (in_duty && duty_idx == i) begin
                    if (wb_sel_i[0]) begin
                        duty_reg[i][7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        duty_reg[i][10:8] <= wb_dat_i[10:8];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Count enable shared by all channels
    mcpwm_prescale u_prescale (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div_i  (div_reg),
        .tick_o (tick)
    );

    // ==========================================================
    // Per-channel registers, counters and pin mapping
    genvar g;
    generate
        for (g = 0; g < `MCPWM_NCH; g = g + 1) begin : g_ch
            wire [1:0] align     = ctrl_reg[g][`MCPWM_C_ALIGN_HI:
                                               `MCPWM_C_ALIGN_LO];
            wire [1:0] mode      = ctrl_reg[g][`MCPWM_C_MODE_HI:
                                               `MCPWM_C_MODE_LO];
            wire [1:0] p_align   = ctrl_reg[g ^ 1][`MCPWM_C_ALIGN_HI:
                                                   `MCPWM_C_ALIGN_LO];
            wire [1:0] p_mode    = ctrl_reg[g ^ 1][`MCPWM_C_MODE_HI:
                                                   `MCPWM_C_MODE_LO];
            wire       freewheel = ctrl_reg[g][`MCPWM_C_FREEWHEEL];
            wire       sign      = ctrl_reg[g][`MCPWM_C_SIGN];
            wire       p_fw      = ctrl_reg[g ^ 1][`MCPWM_C_FREEWHEEL];
            wire       p_sign    = ctrl_reg[g ^ 1][`MCPWM_C_SIGN];
            wire       en        = (align != `MCPWM_AL_OFF);
            // Pair qualifies only when both sides enabled and ask for 11
            wire       dual      = en && (p_align != `MCPWM_AL_OFF)
                                 && (mode == `MCPWM_OM_DUAL)
                                 && (p_mode == `MCPWM_OM_DUAL);
            // Odd channel of a dual pair follows the even channel
            wire       follow    = dual && (g % 2 == 1);
            // Active level follows freewheel select
            wire       wave      = follow
                                 ? (active[g ^ 1] ? p_fw : ~p_fw)
                                 : (active[g] ? freewheel
                                              : ~freewheel);
            wire       dir       = follow ? p_sign : sign;
            reg        m_n;
            reg        p_n;

            // Counter and duty window
            mcpwm_channel u_ch (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .tick_i   (tick),
                .fast_i   (fast_reg),
                .dither_i (jitter_spread_enable_reg),
                .align_i  (align),
                .duty_i   (duty_reg[g]),
                .active_o (active[g])
            );

            // Pin levels per output mode
            always @* begin
                m_n = 1'b0;
                p_n = 1'b0;
                if (en) begin
                    case (mode)
                        `MCPWM_OM_HALF_M: begin
                            m_n = wave;
                        end
                        `MCPWM_OM_HALF_P: begin
                            p_n = wave;
                        end
                        // Lone mode 11 falls back to full bridge
                        default: begin
                            if (!dir) begin
                                m_n = wave;
                                p_n = 1'b1;
                            end else begin
                                m_n = 1'b1;
                                p_n = wave;
                            end
                        end
                    endcase
                end
            end

            assign minus_next[g] = m_n;
            assign plus_next[g]  = p_n;
        end
    endgenerate

    // ==========================================================
    // Pin flip-flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            coil_minus_o <= {`MCPWM_NCH{1'b0}};
            coil_plus_o  <= {`MCPWM_NCH{1'b0}};
        end else begin
            coil_minus_o <= minus_next;
            coil_plus_o  <= plus_next;
        end
    end

    // ==========================================================
    // Read mux
    always @* begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i[7:2] == `MCPWM_ADR_GLOBAL >> 2) begin
            rd_data[`MCPWM_G_FAST]   = fast_reg;
            rd_data[`MCPWM_G_DITHER] = jitter_spread_enable_reg;
            rd_data[`MCPWM_G_DIV_HI:`MCPWM_G_DIV_LO] = div_reg;
        end else if (wb_adr_i[7:2] == `MCPWM_ADR_STATUS >> 2) begin
            rd_data[23:0] = {coil_plus_o, coil_minus_o};
        end else if (in_ctrl) begin
            rd_data[`MCPWM_CTRL_W-1:0] = ctrl_reg[ctrl_idx];
        end else if (in_duty) begin
            rd_data[`MCPWM_DUTY_W-1:0] = duty_reg[duty_idx];
        end
    end

    // ==========================================================
    // Bus answer, one wait state, unmapped reads give zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verif/mcpwm_coil_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Coil loads on all channel pin pairs
module mcpwm_coil_model (
    // Clock
    input  wire logic        clk_i,
    // Pin pairs
    input  wire logic [11:0] minus_i,
    input  wire logic [11:0] plus_i,
    // Positive coil current flag
    output logic      [11:0] fwd_o
);
    // Positive current: plus high, minus low
    always @(posedge clk_i) begin
        fwd_o <= plus_i & ~minus_i;
    end
endmodule
`default_nettype wire

// ==== verif/mcpwm_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus handshake and pin checks
module mcpwm_asserts (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus side
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Coil pins
    input wire logic [11:0] coil_minus_o,
    input wire logic [11:0] coil_plus_o
);
    // Request taken at this edge
    wire logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Common clock and reset
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    ack_latency_a: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(take))
        else $error("ack without request");
    reset_pins_a: assert property ($fell(rst_i) |->
        coil_minus_o == 12'h000 && coil_plus_o == 12'h000)
        else $error("pins not clear after reset");
    reset_bus_a: assert property ($fell(rst_i) |->
        !wb_ack_o && wb_dat_o == 32'h0)
        else $error("bus outputs not clear after reset");
    unmapped_read_a: assert property (take && !wb_we_i &&
        wb_adr_i[7:2] == 6'h03 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_read_a: assert property (take && !wb_we_i &&
        wb_adr_i[7:2] == 6'h01 |=> wb_dat_o[23:0] ==
        {$past(coil_plus_o), $past(coil_minus_o)})
        else $error("status does not show pins");
    read_hold_a: assert property (!$past(rst_i) && $changed(wb_dat_o)
        |-> wb_ack_o && !$past(wb_we_i))
        else $error("read data moved outside a read");
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench top
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [11:0] coil_minus_o;
    logic [11:0] coil_plus_o;
    logic [11:0] fwd;
    logic [31:0] rd;
    logic [1:0]  al;
    logic [10:0] duty [12];
    logic [7:0]  adrs [5] = '{8'h00, 8'h04, 8'h40, 8'h80, 8'h0c};
    logic        fast = 1'b1;
    int          fwd_cnt [12];
    int          plus_cnt [12];
    int          minus_cnt [12];
    int          num_errors = 0;
    int          cmp_count = 0;

    // Clock
    always #5 clk_i = ~clk_i;

    // Design and coil loads
    mcpwm_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .coil_minus_o(coil_minus_o),
        .coil_plus_o(coil_plus_o)
    );
    mcpwm_coil_model coil_u (
        .clk_i(clk_i), .minus_i(coil_minus_o), .plus_i(coil_plus_o),
        .fwd_o(fwd)
    );

    // ==========================================
    // Helpers
    task automatic end_sim();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compare, optionally allowing one count above
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input bit slack);
        cmp_count++;
        if (got !== exp && !(slack && got === exp + 32'h1)) begin
            num_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Control word and duty of one channel, sign 0
    task automatic chan(input int c, input logic [1:0] a,
                        input logic [1:0] md, input logic fw);
        wb(1'b1, 8'h40 + 8'(c * 4), 4'h1, {27'h0, fw, md, a});
        wb(1'b1, 8'h80 + 8'(c * 4), fast ? 4'h1 : 4'h3, {21'h0, duty[c]});
    endtask

    // Count forward current and plus level per channel
    task automatic measure(input int win);
        int xs;
        xs = 0;
        fwd_cnt = '{default: 0};
        plus_cnt = '{default: 0};
        minus_cnt = '{default: 0};
        repeat (win) begin
            @(negedge clk_i);
            if ($isunknown({fwd, coil_plus_o, coil_minus_o})) xs++;
            foreach (fwd_cnt[c]) begin
                fwd_cnt[c] += int'(fwd[c]);
                plus_cnt[c] += int'(coil_plus_o[c]);
                minus_cnt[c] += int'(coil_minus_o[c]);
            end
        end
        check(xs, 0, 0);
        @(posedge clk_i);
    endtask

    // Forward cycles per period; center counts 2*d-1
    function automatic int exp_fwd(input logic [1:0] a, input logic fw,
                                   input int d, input int per);
        int act;
        act = (a == 2'h3) ? 2 * d - 1 : d;
        return fw ? per - act : act;
    endfunction

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h433e));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Cleared registers and unmapped place
        wb(1'b1, 8'h0c, 4'hf, $urandom());
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, adrs[i], 4'hf, 32'h0);
            check(rd, 32'h0, 0);
        end
        // Fast mode, left and right on all channels
        wb(1'b1, 8'h00, 4'h1, 32'h1);
        for (int c = 0; c < 12; c++) begin
            duty[c] = (c == 0) ? 11'h000 : (c == 11) ? 11'h07f :
                      11'($urandom_range(126, 1));
            chan(c, c[0] ? 2'h2 : 2'h1, 2'h2, c[1]);
        end
        repeat (256) @(posedge clk_i);
        measure(128);
        for (int c = 0; c < 12; c++) begin
            al = c[0] ? 2'h2 : 2'h1;
            check(fwd_cnt[c], exp_fwd(al, c[1], duty[c], 128), 0);
            check(plus_cnt[c], 128, 0);
        end
        // Status read while pins run
        wb(1'b0, 8'h04, 4'hf, 32'h0);
        check(rd[23:12], 32'hfff, 0);
        // Center alignment
        for (int c = 1; c < 12; c++) chan(c, 2'h3, 2'h2, c[1]);
        repeat (508) @(posedge clk_i);
        measure(254);
        for (int c = 1; c < 12; c++) begin
            check(fwd_cnt[c], exp_fwd(2'h3, c[1], duty[c], 254), 0);
        end
        // Pairs: dual, lone and disabled partner
        for (int c = 2; c < 8; c++) begin
            chan(c, c == 7 ? 2'h0 : 2'h1, c == 4 ? 2'h2 : 2'h3, 1'b0);
        end
        repeat (256) @(posedge clk_i);
        measure(128);
        check(fwd_cnt[3], duty[2], 0);
        check(fwd_cnt[4], duty[4], 0);
        check(fwd_cnt[5], duty[5], 0);
        check(fwd_cnt[6], duty[6], 0);
        check(plus_cnt[7] + minus_cnt[7], 0, 0);
        // Half bridges, reversed sign, tick every second clock
        wb(1'b1, 8'h00, 4'h3, 32'h101);
        wb(1'b1, 8'h60, 4'h1, 32'h01);
        wb(1'b1, 8'h64, 4'h1, 32'h05);
        wb(1'b1, 8'h68, 4'h1, 32'h29);
        repeat (512) @(posedge clk_i);
        measure(256);
        check(minus_cnt[8], 256 - 2 * duty[8], 0);
        check(plus_cnt[8], 0, 0);
        check(fwd_cnt[9], 256 - 2 * duty[9], 0);
        check(minus_cnt[9], 0, 0);
        check(plus_cnt[10], 256 - 2 * duty[10], 0);
        check(minus_cnt[10], 256, 0);
        check(fwd_cnt[4], 2 * duty[4], 0);
        // Full resolution, then dithered
        fast = 1'b0;
        duty[0] = 11'($urandom_range(2000, 200)) | 11'h001;
        wb(1'b1, 8'h00, 4'h3, 32'h0);
        chan(0, 2'h1, 2'h2, 1'b0);
        repeat (4096) @(posedge clk_i);
        measure(2048);
        check(fwd_cnt[0], duty[0], 0);
        wb(1'b1, 8'h00, 4'h1, 32'h2);
        repeat (4096) @(posedge clk_i);
        measure(2048);
        check(fwd_cnt[0], duty[0], 0);
        measure(1024);
        check(fwd_cnt[0], duty[0] >> 1, 1);
        end_sim();
    end

    // Hang guard, well past the expected run
    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        end_sim();
    end
endmodule

bind mcpwm_top mcpwm_asserts chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .coil_minus_o(coil_minus_o), .coil_plus_o(coil_plus_o)
);
`default_nettype wire
